// ---- design/analog_comparator_control.sv ----
// Top of the analog comparator control block with its Avalon-MM register slave.
`timescale 1ns/100ps
module analog_comparator_control
(
   input  wire logic                                  i_ref_clk,
   input  wire logic                                  i_reset,
   input  wire logic [comparator_pkg::ADDR_W-1:0]     i_avs_address,
   input  wire logic                                  i_avs_read,
   input  wire logic                                  i_avs_write,
   input  wire logic [31:0]                           i_avs_writedata,
   input  wire logic [3:0]                            i_avs_byteenable,
   output logic      [31:0]                           o_avs_readdata,
   output logic                                       o_avs_waitrequest,
   input  wire logic                                  i_comparator_result,
   input  wire logic                                  i_global_irq_enable,
   input  wire logic                                  i_irq_vector_taken,
   input  wire logic                                  i_converter_on,
   input  wire logic                                  i_positive_pin,
   input  wire logic                                  i_negative_pin,
   output logic                                       o_comparator_power_off,
   output logic                                       o_bandgap_positive_select,
   output logic                                       o_negative_from_channel,
   output logic      [comparator_pkg::CHANNEL_W-1:0]  o_negative_channel,
   output logic                                       o_comparator_irq,
   output logic                                       o_capture_route,
   output logic                                       o_capture_input,
   output logic                                       o_positive_pin_buffer_off,
   output logic                                       o_negative_pin_buffer_off,
   output logic                                       o_positive_pin_value,
   output logic                                       o_negative_pin_value
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic                                  power_off_r;
   logic                                  power_off_nxt;
   logic                                  bandgap_r;
   logic                                  bandgap_nxt;
   logic                                  irq_enable_r;
   logic                                  irq_enable_nxt;
   logic                                  capture_route_r;
   logic                                  capture_route_nxt;
   comparator_pkg::irq_mode_e             mode_r;
   comparator_pkg::irq_mode_e             mode_nxt;
   logic                                  event_flag_r;
   logic                                  event_flag_nxt;
   logic                                  neg_buf_off_r;
   logic                                  neg_buf_off_nxt;
   logic                                  pos_buf_off_r;
   logic                                  pos_buf_off_nxt;
   logic                                  mux_enable_r;
   logic                                  mux_enable_nxt;
   logic [comparator_pkg::CHANNEL_W-1:0]  channel_r;
   logic [comparator_pkg::CHANNEL_W-1:0]  channel_nxt;
   logic                                  capture_r;
   logic                                  capture_nxt;
   logic                                  neg_from_channel_r;
   logic                                  neg_from_channel_nxt;

   logic                                  ack_r;
   logic                                  ack_nxt;
   logic [31:0]                           readdata_r;
   logic [31:0]                           readdata_nxt;

   logic [6:0]                            word_index;
   logic                                  request;
   logic                                  write_done;
   logic                                  low_lane;
   logic                                  wr_ctrl;
   logic                                  wr_pins;
   logic                                  wr_mux;
   logic                                  event_hit;
   logic [7:0]                            ctrl_status_view;
   logic [7:0]                            pin_buf_view;
   logic [7:0]                            mux_cfg_view;
   logic [1:0]                            pin_values;

   comparator_event_if                    cmp_ev ();

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchroniser and edge detector.

   // The analog core drives i_comparator_result high when the positive input exceeds the negative.
   comparator_sync u_sync
   (
      .i_ref_clk   (i_ref_clk),
      .i_reset     (i_reset),
      .i_raw       (i_comparator_result),
      .i_power_off (power_off_r),
      .ev          (cmp_ev.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Digital input buffers of the two comparator pins.

   pin_buffer_gate #(.N(2)) u_pins
   (
      .i_ref_clk    (i_ref_clk),
      .i_reset      (i_reset),
      .i_pin        ({i_negative_pin, i_positive_pin}),
      .i_buffer_off ({neg_buf_off_r, pos_buf_off_r}),
      .o_value      (pin_values)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   // A request waits one cycle and completes on the edge where ack_r is high.
   assign word_index = i_avs_address[comparator_pkg::ADDR_W-1:2];
   assign request    = i_avs_read | i_avs_write;
   assign write_done = i_avs_write & ack_r;
   assign low_lane   = i_avs_byteenable[0];
   assign wr_ctrl    = write_done & low_lane & (word_index == comparator_pkg::CTRL_STATUS_IDX);
   assign wr_pins    = write_done & low_lane & (word_index == comparator_pkg::PIN_BUF_DIS_IDX);
   assign wr_mux     = write_done & low_lane & (word_index == comparator_pkg::NEG_MUX_CFG_IDX);

   ////////////////////////////////////////////////////////////////////////////
   // Register views.

   always_comb
   begin
      ctrl_status_view                                 = 8'h00;
      ctrl_status_view[comparator_pkg::POWER_OFF_BIT]  = power_off_r;
      ctrl_status_view[comparator_pkg::BANDGAP_BIT]    = bandgap_r;
      ctrl_status_view[comparator_pkg::SYNC_OUT_BIT]   = cmp_ev.sync_out;
      ctrl_status_view[comparator_pkg::EVENT_FLAG_BIT] = event_flag_r;
      ctrl_status_view[comparator_pkg::IRQ_ENABLE_BIT] = irq_enable_r;
      ctrl_status_view[comparator_pkg::CAPTURE_BIT]    = capture_route_r;
      ctrl_status_view[comparator_pkg::MODE_HI_BIT]    = mode_r[1];
      ctrl_status_view[comparator_pkg::MODE_LO_BIT]    = mode_r[0];
      pin_buf_view                                     = 8'h00;
      pin_buf_view[comparator_pkg::NEG_BUF_OFF_BIT]    = neg_buf_off_r;
      pin_buf_view[comparator_pkg::POS_BUF_OFF_BIT]    = pos_buf_off_r;
      mux_cfg_view                                     = 8'h00;
      mux_cfg_view[comparator_pkg::MUX_ENABLE_BIT]     = mux_enable_r;
      mux_cfg_view[comparator_pkg::CHANNEL_LSB +: comparator_pkg::CHANNEL_W] = channel_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer.

   always_comb
   begin
      ack_nxt      = request & ~ack_r;
      readdata_nxt = readdata_r;
      if (i_avs_read & ~ack_r)
      begin
         case (word_index)
            comparator_pkg::CTRL_STATUS_IDX: readdata_nxt = {24'h000000, ctrl_status_view};
            comparator_pkg::PIN_BUF_DIS_IDX: readdata_nxt = {24'h000000, pin_buf_view};
            comparator_pkg::NEG_MUX_CFG_IDX: readdata_nxt = {24'h000000, mux_cfg_view};
            default:                         readdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ack_r      <= 1'b0;
         readdata_r <= 32'h00000000;
      end
      else
      begin
         ack_r      <= ack_nxt;
         readdata_r <= readdata_nxt;
      end
   end

   assign o_avs_waitrequest = request & ~ack_r;
   assign o_avs_readdata    = readdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Event selection.

   always_comb
   begin
      case (mode_r)
         comparator_pkg::MODE_TOGGLE:   event_hit = cmp_ev.rise | cmp_ev.fall;
         comparator_pkg::MODE_FALLING:  event_hit = cmp_ev.fall;
         comparator_pkg::MODE_RISING:   event_hit = cmp_ev.rise;
         comparator_pkg::MODE_RESERVED: event_hit = 1'b0;
         default:                       event_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, status and configuration registers.

   always_comb
   begin
      power_off_nxt        = power_off_r;
      bandgap_nxt          = bandgap_r;
      irq_enable_nxt       = irq_enable_r;
      capture_route_nxt    = capture_route_r;
      mode_nxt             = mode_r;
      neg_buf_off_nxt      = neg_buf_off_r;
      pos_buf_off_nxt      = pos_buf_off_r;
      mux_enable_nxt       = mux_enable_r;
      channel_nxt          = channel_r;
      event_flag_nxt       = event_flag_r;
      if (wr_ctrl)
      begin
         power_off_nxt     = i_avs_writedata[comparator_pkg::POWER_OFF_BIT];
         bandgap_nxt       = i_avs_writedata[comparator_pkg::BANDGAP_BIT];
         irq_enable_nxt    = i_avs_writedata[comparator_pkg::IRQ_ENABLE_BIT];
         capture_route_nxt = i_avs_writedata[comparator_pkg::CAPTURE_BIT];
         mode_nxt          = comparator_pkg::irq_mode_e'(
                                i_avs_writedata[comparator_pkg::MODE_HI_BIT:
                                                comparator_pkg::MODE_LO_BIT]);
         if (i_avs_writedata[comparator_pkg::EVENT_FLAG_BIT])
         begin
            event_flag_nxt = 1'b0;
         end
      end
      if (i_irq_vector_taken)
      begin
         event_flag_nxt    = 1'b0;
      end
      if (event_hit)
      begin
         event_flag_nxt    = 1'b1;
      end
      if (wr_pins)
      begin
         neg_buf_off_nxt   = i_avs_writedata[comparator_pkg::NEG_BUF_OFF_BIT];
         pos_buf_off_nxt   = i_avs_writedata[comparator_pkg::POS_BUF_OFF_BIT];
      end
      if (wr_mux)
      begin
         mux_enable_nxt    = i_avs_writedata[comparator_pkg::MUX_ENABLE_BIT];
         channel_nxt       = i_avs_writedata[comparator_pkg::CHANNEL_LSB +:
                                             comparator_pkg::CHANNEL_W];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         power_off_r     <= comparator_pkg::CTRL_STATUS_RST[comparator_pkg::POWER_OFF_BIT];
         bandgap_r       <= comparator_pkg::CTRL_STATUS_RST[comparator_pkg::BANDGAP_BIT];
         irq_enable_r    <= comparator_pkg::CTRL_STATUS_RST[comparator_pkg::IRQ_ENABLE_BIT];
         capture_route_r <= comparator_pkg::CTRL_STATUS_RST[comparator_pkg::CAPTURE_BIT];
         mode_r          <= comparator_pkg::MODE_TOGGLE;
         event_flag_r    <= comparator_pkg::CTRL_STATUS_RST[comparator_pkg::EVENT_FLAG_BIT];
         neg_buf_off_r   <= comparator_pkg::PIN_BUF_DIS_RST[comparator_pkg::NEG_BUF_OFF_BIT];
         pos_buf_off_r   <= comparator_pkg::PIN_BUF_DIS_RST[comparator_pkg::POS_BUF_OFF_BIT];
         mux_enable_r    <= comparator_pkg::NEG_MUX_CFG_RST[comparator_pkg::MUX_ENABLE_BIT];
         channel_r       <= comparator_pkg::NEG_MUX_CFG_RST[comparator_pkg::CHANNEL_LSB +:
                                                            comparator_pkg::CHANNEL_W];
      end
      else
      begin
         power_off_r     <= power_off_nxt;
         bandgap_r       <= bandgap_nxt;
         irq_enable_r    <= irq_enable_nxt;
         capture_route_r <= capture_route_nxt;
         mode_r          <= mode_nxt;
         event_flag_r    <= event_flag_nxt;
         neg_buf_off_r   <= neg_buf_off_nxt;
         pos_buf_off_r   <= pos_buf_off_nxt;
         mux_enable_r    <= mux_enable_nxt;
         channel_r       <= channel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture route and negative input selection.

   always_comb
   begin
      capture_nxt          = capture_route_r & cmp_ev.sync_out;
      neg_from_channel_nxt = mux_enable_r & ~i_converter_on;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         capture_r          <= 1'b0;
         neg_from_channel_r <= 1'b0;
      end
      else
      begin
         capture_r          <= capture_nxt;
         neg_from_channel_r <= neg_from_channel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign o_comparator_power_off    = power_off_r;
   assign o_bandgap_positive_select = bandgap_r;
   assign o_negative_from_channel   = neg_from_channel_r;
   assign o_negative_channel        = channel_r;
   assign o_comparator_irq          = event_flag_r & irq_enable_r & i_global_irq_enable;
   assign o_capture_route           = capture_route_r;
   assign o_capture_input           = capture_r;
   assign o_positive_pin_buffer_off = pos_buf_off_r;
   assign o_negative_pin_buffer_off = neg_buf_off_r;
   assign o_positive_pin_value      = pin_values[0];
   assign o_negative_pin_value      = pin_values[1];

endmodule

// ---- design/comparator_event_if.sv ----
// Carrier of the synchronised comparator output and its edges.
`timescale 1ns/100ps
interface comparator_event_if;
   logic sync_out;
   logic rise;
   logic fall;

   modport src
   (
      output sync_out,
      output rise,
      output fall
   );

   modport dst
   (
      input  sync_out,
      input  rise,
      input  fall
   );
endinterface

// ---- design/comparator_pkg.sv ----
// Constants and types shared by the analog comparator control logic.
package comparator_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [6:0] CTRL_STATUS_IDX   = 7'h50;
   localparam logic [6:0] NEG_MUX_CFG_IDX   = 7'h51;
   localparam logic [6:0] PIN_BUF_DIS_IDX   = 7'h7f;
   localparam int         ADDR_W            = 9;

   // Field positions of comparator_control_status.
   localparam int POWER_OFF_BIT   = 7;
   localparam int BANDGAP_BIT     = 6;
   localparam int SYNC_OUT_BIT    = 5;
   localparam int EVENT_FLAG_BIT  = 4;
   localparam int IRQ_ENABLE_BIT  = 3;
   localparam int CAPTURE_BIT     = 2;
   localparam int MODE_HI_BIT     = 1;
   localparam int MODE_LO_BIT     = 0;

   // Field positions of comparator_pin_buffer_disable.
   localparam int NEG_BUF_OFF_BIT = 1;
   localparam int POS_BUF_OFF_BIT = 0;

   // Field positions of the negative input multiplexer configuration.
   localparam int MUX_ENABLE_BIT  = 4;
   localparam int CHANNEL_LSB     = 0;
   localparam int CHANNEL_W       = 4;

   // Values after reset.
   localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
   localparam logic [7:0] PIN_BUF_DIS_RST = 8'h00;
   localparam logic [7:0] NEG_MUX_CFG_RST = 8'h00;

   // Number of synchroniser stages in front of the comparator output.
   localparam int SYNC_STAGES     = 2;

   typedef enum logic [1:0]
   {
      MODE_TOGGLE   = 2'b00,
      MODE_RESERVED = 2'b01,
      MODE_FALLING  = 2'b10,
      MODE_RISING   = 2'b11
   } irq_mode_e;

endpackage

// ---- design/comparator_sync.sv ----
// Synchroniser and edge detector for the raw comparator result.
`timescale 1ns/100ps
module comparator_sync
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_raw,
   input  wire logic        i_power_off,
   comparator_event_if.src  ev
);

   logic stage1_r;
   logic stage1_nxt;
   logic stage2_r;
   logic stage2_nxt;
   logic prev_r;
   logic prev_nxt;

   // Two stages give one to two cycles of latency; power off holds zero.
   always_comb
   begin
      stage1_nxt = i_raw;
      stage2_nxt = i_power_off ? 1'b0 : stage1_r;
      prev_nxt   = stage2_r;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         prev_r   <= 1'b0;
      end
      else
      begin
         stage1_r <= stage1_nxt;
         stage2_r <= stage2_nxt;
         prev_r   <= prev_nxt;
      end
   end

   // Edges compare the present and previous synchronised values.
   assign ev.sync_out = stage2_r;
   assign ev.rise     = stage2_r & ~prev_r & ~i_power_off;
   assign ev.fall     = ~stage2_r & prev_r & ~i_power_off;

endmodule

// ---- design/pin_buffer_gate.sv ----
// Digital input path of the comparator pins with buffer disable.
`timescale 1ns/100ps
module pin_buffer_gate
#(
   parameter int N = 2
)
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_reset,
   input  wire logic [N-1:0]  i_pin,
   input  wire logic [N-1:0]  i_buffer_off,
   output logic      [N-1:0]  o_value
);

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : gen_pin
         logic meta_r;
         logic hold_r;
         logic value_r;
         logic value_nxt;

         // A disabled buffer reads as zero.
         always_comb
         begin
            value_nxt = i_buffer_off[g] ? 1'b0 : hold_r;
         end

         always_ff @(posedge i_ref_clk)
         begin
            if (i_reset)
            begin
               meta_r  <= 1'b0;
               hold_r  <= 1'b0;
               value_r <= 1'b0;
            end
            else
            begin
               meta_r  <= i_pin[g];
               hold_r  <= meta_r;
               value_r <= value_nxt;
            end
         end

         assign o_value[g] = value_r;
      end
   endgenerate

endmodule

// ---- tb/analog_comparator_control_assertions.sv ----
// Concurrent checks on the ports of the analog comparator control block.
`timescale 1ns/100ps
module comparator_control_checker
(
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   input wire logic [8:0]  i_avs_address,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_comparator_result,
   input wire logic        i_global_irq_enable,
   input wire logic        i_converter_on,
   input wire logic        o_comparator_power_off,
   input wire logic        o_bandgap_positive_select,
   input wire logic        o_negative_from_channel,
   input wire logic        o_comparator_irq,
   input wire logic        o_capture_route,
   input wire logic        o_capture_input,
   input wire logic        o_positive_pin_buffer_off,
   input wire logic        o_negative_pin_buffer_off,
   input wire logic        o_positive_pin_value,
   input wire logic        o_negative_pin_value
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   wire logic en = o_capture_route && !o_comparator_power_off;
   wire logic ctrl_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                        && i_avs_address[8:2] == comparator_pkg::CTRL_STATUS_IDX;
   ////////////////////////////////////////////////////////////////////////////////
   property p_ctrl_write;
      ctrl_wr |=> o_comparator_power_off == $past(i_avs_writedata[7])
         && o_bandgap_positive_select == $past(i_avs_writedata[6])
         && o_capture_route == $past(i_avs_writedata[2])
         && (!o_comparator_irq || $past(i_avs_writedata[3]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
   property p_gie;
      o_comparator_irq |-> i_global_irq_enable;
   endproperty
   a_gie: assert property (p_gie) else $error("irq without global enable");
   property p_route_off;
      !o_capture_route |=> !o_capture_input;
   endproperty
   a_route_off: assert property (p_route_off) else $error("capture fed while unrouted");
   property p_cap_early;
      (en && !i_comparator_result) [*3] ##1 (en && i_comparator_result) |=> !o_capture_input [*2];
   endproperty
   a_cap_early: assert property (p_cap_early) else $error("output passed too soon");
   property p_cap_rise;
      (en && !i_comparator_result) [*3] ##1 (en && i_comparator_result) [*3] |=> o_capture_input;
   endproperty
   a_cap_rise: assert property (p_cap_rise) else $error("output passed too late");
   property p_pwr;
      o_comparator_power_off [*3] |-> !o_capture_input;
   endproperty
   a_pwr: assert property (p_pwr) else $error("output live while powered off");
   property p_pos_buf;
      o_positive_pin_buffer_off [*2] |-> !o_positive_pin_value;
   endproperty
   a_pos_buf: assert property (p_pos_buf) else $error("positive pin reads one");
   property p_neg_buf;
      o_negative_pin_buffer_off [*2] |-> !o_negative_pin_value;
   endproperty
   a_neg_buf: assert property (p_neg_buf) else $error("negative pin reads one");
   property p_conv;
      i_converter_on |=> !o_negative_from_channel;
   endproperty
   a_conv: assert property (p_conv) else $error("channel used with converter on");
   c_irq: cover property (o_comparator_irq);
   c_cap: cover property (o_capture_input);
   c_pwr: cover property (ctrl_wr && i_avs_writedata[7]);
endmodule

// ---- tb/comparator_core_model.sv ----
// Behavioural analog comparator core that drives the raw comparator result.
`timescale 1ns/100ps
module comparator_core_model
#(
   parameter logic [7:0] BANDGAP_LEVEL = 8'h80
)
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_power_off,
   input  wire logic       i_bandgap_select,
   input  wire logic       i_from_channel,
   input  wire logic [7:0] i_pos_level,
   input  wire logic [7:0] i_neg_level,
   input  wire logic [7:0] i_chan_level,
   output logic            o_result
);
   logic [7:0] plus_lvl;
   logic [7:0] minus_lvl;
   logic       junk = 1'b0;
   // An unpowered core gives no valid result, so it wanders every cycle.
   always @(posedge i_ref_clk) junk <= ~junk;
   assign plus_lvl = i_bandgap_select ? BANDGAP_LEVEL : i_pos_level;
   assign minus_lvl = i_from_channel ? i_chan_level : i_neg_level;
   assign o_result = i_power_off ? junk : (plus_lvl > minus_lvl);
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the analog comparator control block.
`timescale 1ns/100ps
module tb;
   localparam logic [7:0] BG   = 8'h80;
   localparam logic [8:0] CTRL = {comparator_pkg::CTRL_STATUS_IDX, 2'b00};
   localparam logic [8:0] MUXC = {comparator_pkg::NEG_MUX_CFG_IDX, 2'b00};
   localparam logic [8:0] PBUF = {comparator_pkg::PIN_BUF_DIS_IDX, 2'b00};
   logic        i_ref_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic [8:0]  i_avs_address = 9'h000;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0000_0000;
   logic [3:0]  i_avs_byteenable = 4'h1;
   logic        i_global_irq_enable = 1'b0;
   logic        i_irq_vector_taken = 1'b0;
   logic        i_converter_on = 1'b0;
   logic        i_positive_pin = 1'b0;
   logic        i_negative_pin = 1'b0;
   logic [7:0]  pos_lvl = 8'h10;
   logic [7:0]  neg_lvl = 8'h40;
   logic [7:0]  chan_lvl = 8'h20;
   logic [31:0] o_avs_readdata;
   logic [3:0]  o_negative_channel;
   logic        o_avs_waitrequest, i_comparator_result, o_comparator_power_off;
   logic        o_bandgap_positive_select, o_negative_from_channel, o_comparator_irq;
   logic        o_capture_route, o_capture_input, o_positive_pin_value, o_negative_pin_value;
   logic        o_positive_pin_buffer_off, o_negative_pin_buffer_off;
   logic [7:0]  ctrl_sh = 8'h00;
   logic [7:0]  mux_sh = 8'h00;
   logic [7:0]  q;
   logic [31:0] r = 32'h0000_0000;
   logic [31:0] s;
   int          seed = 82;
   int          mismatches = 0;
   int          checked = 0;
   analog_comparator_control u_analog_comparator_control (.*);
   comparator_core_model #(.BANDGAP_LEVEL(BG)) u_comparator_core_model
   (
      .i_ref_clk, .i_power_off(o_comparator_power_off), .i_pos_level(pos_lvl),
      .i_bandgap_select(o_bandgap_positive_select), .i_from_channel(o_negative_from_channel),
      .i_neg_level(neg_lvl), .i_chan_level(chan_lvl), .o_result(i_comparator_result)
   );
   always #25 i_ref_clk = ~i_ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_writedata <= {r[31:8], d};
      i_avs_byteenable <= {r[30:28], 1'b1};
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do
         @(posedge i_ref_clk);
      while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata[7:0];
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task automatic wctrl(input logic [7:0] d);
      ctrl_sh = d;
      bus(1'b1, CTRL, d);
   endtask
   task automatic settle;
      repeat (5) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   function automatic logic exp_raw();
      return !ctrl_sh[7] && ((ctrl_sh[6] ? BG : pos_lvl) >
                             ((mux_sh[4] && !i_converter_on) ? chan_lvl : neg_lvl));
   endfunction
   function automatic logic exp_flag(input logic [1:0] m, input logic rising);
      return (m == 2'b00) || (rising ? (m == 2'b11) : (m == 2'b10));
   endfunction
   task automatic final_report;
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      bus(1'b0, PBUF, 8'h00);
      chk(q, 8'h00, "pin disable reset");
      bus(1'b0, 9'h000, 8'h00);
      chk(q, 8'h00, "unmapped read");
      for (int m = 0; m < 4; m++)
      begin
         wctrl({6'b000100, m[1:0]});
         pos_lvl <= 8'h60;
         settle;
         bus(1'b0, CTRL, 8'h00);
         chk(q & 8'h30, {3'b001, exp_flag(m[1:0], 1'b1), 4'h0}, "rise flag");
         wctrl(ctrl_sh);
         pos_lvl <= 8'h10;
         settle;
         bus(1'b0, CTRL, 8'h00);
         chk(q & 8'h30, {3'b000, exp_flag(m[1:0], 1'b0), 4'h0}, "fall flag");
      end
      wctrl(8'h13);
      wctrl(8'h0b);
      for (int g = 0; g < 2; g++)
      begin
         i_global_irq_enable <= g[0];
         pos_lvl <= 8'h60;
         settle;
         chk({7'h00, o_comparator_irq}, {7'h00, g[0]}, "irq");
         @(posedge i_ref_clk);
         i_irq_vector_taken <= 1'b1;
         @(posedge i_ref_clk);
         i_irq_vector_taken <= 1'b0;
         pos_lvl <= 8'h10;
         settle;
         chk({7'h00, o_comparator_irq}, 8'h00, "irq after vector");
      end
      wctrl(8'h13);
      wctrl(8'h80);
      settle;
      bus(1'b0, CTRL, 8'h00);
      chk(q, 8'h80, "powered off");
      wctrl(8'h10);
      for (int k = 0; k < 40; k++)
      begin
         r = $random(seed);
         s = $random(seed);
         wctrl({r[7:6], 3'b100, r[2], 2'b01});
         mux_sh = {3'b000, r[12:8]};
         bus(1'b1, MUXC, mux_sh);
         bus(1'b1, PBUF, r[23:16]);
         i_converter_on <= r[13];
         i_positive_pin <= r[14];
         i_negative_pin <= r[15];
         pos_lvl <= (k == 0) ? s[15:8] : s[7:0];
         neg_lvl <= s[15:8];
         chan_lvl <= s[23:16];
         settle;
         chk({7'h00, o_capture_input}, {7'h00, ctrl_sh[2] & exp_raw()}, "capture");
         chk({3'b000, o_negative_from_channel, o_negative_channel},
             {3'b000, mux_sh[4] & !i_converter_on, mux_sh[3:0]}, "neg select");
         chk({6'h00, o_negative_pin_value, o_positive_pin_value},
             {6'h00, i_negative_pin & !r[17], i_positive_pin & !r[16]}, "pins");
         chk({4'h0, o_negative_pin_buffer_off, o_positive_pin_buffer_off,
              o_bandgap_positive_select, o_capture_route},
             {4'h0, r[17:16], ctrl_sh[6], ctrl_sh[2]}, "outputs");
         bus(1'b0, CTRL, 8'h00);
         chk(q, {ctrl_sh[7:6], exp_raw(), 1'b0, ctrl_sh[3:0]}, "ctrl");
         bus(1'b0, PBUF, 8'h00);
         chk(q, {6'h00, r[17:16]}, "pin disable");
      end
      final_report;
   end
   initial
   begin
      repeat (8000) @(posedge i_ref_clk);
      mismatches++;
      final_report;
   end
endmodule
bind analog_comparator_control comparator_control_checker u_comparator_control_checker (.*);
